// *** hce_encoder.sv ***
// Purpose: Button-woken hopping code word encoder and serial modulator
// Assumes: Pins pass two flip-flops; register port on i_clock
// Notes:   Storage words stand in an array here; cipher is a sub-module
//
// Notes on behaviour
// - Any switch closure wakes the device; debounce about 6.5 ms, then sample.
// - Capture buttons and advance 16-bit sync counter before encrypting.
// - Encryption is a block transform, 32-bit block, 64-bit key.
// - Plaintext holds sync counter, discrimination bits and button state.
// - Word is 67 bits: hop 32, serial 28 or 32, status 7 or 3.
// - Fixed part 35 bits: serial, function code, status bit, 2-bit CRC.
// - Low battery is sent as a status bit in the word.
// - Held buttons repeat the same word until release or time-out.
// - A newly pressed button restarts debounce; word is abandoned.
// - Partial release changes nothing; full release ends word, then sleep.
// - Four switch inputs form a code of up to 15 functions.
// - In programming mode switch 3, or else switch 2, is serial clock.
// - In programming mode the modulated output pin is the data line.
// - Indicator output sinks current while transmitting.
// - Keys and codes are unreadable except for verify after programming.
// - Serializer offers pulse-width and variable pulse-width, selectable rate.
// - Config bit picks 1667 or 833 bits per second.
// - Config bit picks pulse widths 1/6,2/6 or 1/3,2/3.
// - Seed enabled plus seed button code sends seeds and serial upper word.
// - Blank-alternate bit silences every second word slot.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "hce_consts.svh"
module hce_encoder
    import hce_pkg::*;
#(
    parameter int DEBOUNCE_CYC  = (`HCE_DEBOUNCE_NS + `HCE_CLK_NS - 1) / `HCE_CLK_NS,
    parameter int BIT_CYC_SLOW  = `HCE_CLK_HZ / `HCE_RATE_SLOW_BPS,
    parameter int BIT_CYC_FAST  = `HCE_CLK_HZ / `HCE_RATE_FAST_BPS,
    parameter int GUARD_SLOTS   = 15,
    parameter int MAX_WORDS     = 255
) (
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic [3:0]  i_switch_in,
    input  wire logic        i_low_battery,
    input  wire logic        i_prog_enable,
    input  wire logic        i_prog_clock_alt,
    input  wire logic        i_pwm_data,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_write,
    input  wire logic        i_read,
    output logic      [15:0] o_rdata,
    output logic             o_pwm,
    output logic             o_pwm_oe,
    output logic             o_led_n
);
    localparam int SLOT_SW = BIT_CYC_SLOW / `HCE_SLOTS_WIDE;
    localparam int SLOT_SN = BIT_CYC_SLOW / `HCE_SLOTS_NARROW;
    localparam int SLOT_FW = BIT_CYC_FAST / `HCE_SLOTS_WIDE;
    localparam int SLOT_FN = BIT_CYC_FAST / `HCE_SLOTS_NARROW;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [7:0] sync1_reg, sync2_reg;
    logic       sclk_d_reg;
    logic [3:0] sw;
    logic       lowbat, prog_en, prog_alt, pdata, sclk, sclk_rise;

    // Two flip-flops on every pin input
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sync1_reg  <= 8'h00;
            sync2_reg  <= 8'h00;
            sclk_d_reg <= 1'b0;
        end else begin
            sync1_reg  <= {i_low_battery, i_prog_enable, i_prog_clock_alt, i_pwm_data,
                           i_switch_in};
            sync2_reg  <= sync1_reg;
            sclk_d_reg <= sclk;
        end
    end

    assign sw        = sync2_reg[3:0];
    assign pdata     = sync2_reg[4];
    assign prog_alt  = sync2_reg[5];
    assign prog_en   = sync2_reg[6];
    assign lowbat    = sync2_reg[7];
    assign sclk      = prog_alt ? sw[2] : sw[3];
    assign sclk_rise = sclk && !sclk_d_reg;

    // ----------------------------------------
    // Storage words and configuration
    // ----------------------------------------
    logic [15:0] mem [`HCE_NUM_WORDS];
    logic        mem_we;
    logic [3:0]  mem_waddr;
    logic [15:0] mem_wdata;
    logic [15:0] cfg;
    logic [63:0] key;

    assign cfg = mem[`HCE_ADDR_CONFIG];
    assign key = {mem[3], mem[2], mem[1], mem[0]};

    // ----------------------------------------
    // Main control state
    // ----------------------------------------
    hce_state_t     state_reg,  state_next;
    logic [31:0]    cnt_reg,    cnt_next;
    logic [3:0]     btn_reg,    btn_next;
    hce_code_word_t word_reg,   word_next;
    logic [6:0]     bit_reg,    bit_next;
    logic [2:0]     slot_reg,   slot_next;
    logic [7:0]     words_reg,  words_next;
    logic           blank_reg,  blank_next;
    logic           phase_reg,  phase_next;
    logic           start_reg,  start_next;
    logic [15:0]    shift_reg,  shift_next;
    logic [3:0]     pbit_reg,   pbit_next;
    logic [3:0]     pword_reg,  pword_next;
    logic           verify_reg, verify_next;
    logic           pwm_reg,    pwm_next;
    logic           oe_reg,     oe_next;
    logic           led_n_reg,  led_n_next;
    logic [15:0]    rdata_reg,  rdata_next;
    logic [31:0]    hop;
    logic           hop_done;
    logic [31:0]    slot_cyc;
    logic [2:0]     slots;
    logic           cur_bit, slot_end;
    logic [31:0]    plain;
    hce_code_word_t built;

    // Block transform, replaceable
    hce_cipher u_cipher (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_start (start_reg),
        .i_block (plain),
        .i_key   (key),
        .o_block (hop),
        .o_done  (hop_done)
    );

    // Plaintext and word assembly
    always_comb begin
        plain = {btn_reg, cfg[`HCE_CFG_OVR], mem[`HCE_ADDR_SER0][10:0],
                 mem[`HCE_ADDR_SYNC]};
        built.hop  = hop;
        built.vlow = lowbat;
        if (cfg[`HCE_CFG_XSER]) begin
            built.fixed = {mem[`HCE_ADDR_SER1], mem[`HCE_ADDR_SER0]};
        end else begin
            built.fixed = {btn_reg, mem[`HCE_ADDR_SER1][11:0], mem[`HCE_ADDR_SER0]};
        end
        if (cfg[`HCE_CFG_SEED_EN] && (btn_reg == `HCE_SEED_CODE_A ||
                                      btn_reg == `HCE_SEED_CODE_B)) begin
            built.hop   = {mem[`HCE_ADDR_SEED1], mem[`HCE_ADDR_SEED0]};
            built.fixed = {mem[`HCE_ADDR_SER1], mem[`HCE_ADDR_SEED2]};
        end
        built.crc = 2'b00;
        for (int i = 0; i < 65; i++) begin
            built.crc[i % 2] = built.crc[i % 2] ^ built[i];
        end
    end

    // Slot timing from rate and format bits
    always_comb begin
        slots = (cfg[`HCE_CFG_FORMAT] && !cfg[`HCE_CFG_VPWM]) ?
                3'(`HCE_SLOTS_NARROW) : 3'(`HCE_SLOTS_WIDE);
        if (cfg[`HCE_CFG_FAST]) begin
            slot_cyc = (slots == 3'(`HCE_SLOTS_WIDE)) ? 32'(SLOT_FW) : 32'(SLOT_FN);
        end else begin
            slot_cyc = (slots == 3'(`HCE_SLOTS_WIDE)) ? 32'(SLOT_SW) : 32'(SLOT_SN);
        end
        slot_end = (cnt_reg == slot_cyc - 32'd1);
        cur_bit  = word_reg[bit_reg];
    end

    // Next-state logic for sequencing, serializer, programming and bus
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        btn_next    = btn_reg;
        word_next   = word_reg;
        bit_next    = bit_reg;
        slot_next   = slot_reg;
        words_next  = words_reg;
        blank_next  = blank_reg;
        phase_next  = phase_reg;
        start_next  = 1'b0;
        shift_next  = shift_reg;
        pbit_next   = pbit_reg;
        pword_next  = pword_reg;
        verify_next = verify_reg;
        pwm_next    = 1'b0;
        oe_next     = 1'b1;
        led_n_next  = 1'b1;
        mem_we      = 1'b0;
        mem_waddr   = i_addr;
        mem_wdata   = i_wdata;
        rdata_next  = 16'h0000;
        case (state_reg)
            ST_SLEEP: begin
                cnt_next = 32'd0;
                if (prog_en) begin
                    state_next = ST_PROG;
                    pbit_next  = 4'h0;
                    pword_next = 4'h0;
                end else if (sw != 4'h0) begin
                    state_next = ST_DEBOUNCE;
                end
            end
            ST_DEBOUNCE: begin
                cnt_next = cnt_reg + 32'd1;
                if (cnt_reg == 32'(DEBOUNCE_CYC - 1)) begin
                    state_next = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                btn_next   = sw;
                words_next = 8'h00;
                blank_next = 1'b0;
                phase_next = 1'b0;
                state_next = (sw == 4'h0) ? ST_SLEEP : ST_WRITEBACK;
            end
            ST_WRITEBACK: begin
                mem_we     = 1'b1;
                mem_waddr  = `HCE_ADDR_SYNC;
                mem_wdata  = mem[`HCE_ADDR_SYNC] + 16'h0001;
                start_next = 1'b1;
                state_next = ST_ENCRYPT;
            end
            ST_ENCRYPT: begin
                cnt_next = 32'd0;
                if (hop_done) begin
                    word_next  = built;
                    bit_next   = 7'd0;
                    slot_next  = 3'd0;
                    state_next = ST_SEND;
                end
            end
            ST_SEND: begin
                led_n_next = 1'b0;
                if (!blank_reg) begin
                    if (cfg[`HCE_CFG_VPWM]) begin
                        pwm_next = phase_reg ^ (slot_reg >= (cur_bit ? 3'd2 : 3'd1));
                    end else begin
                        pwm_next = (slot_reg < (cur_bit ? 3'd1 : 3'd2));
                    end
                end
                cnt_next = slot_end ? 32'd0 : cnt_reg + 32'd1;
                if (slot_end) begin
                    slot_next = slot_reg + 3'd1;
                    if (slot_reg == slots - 3'd1) begin
                        slot_next  = 3'd0;
                        phase_next = !phase_reg;
                        bit_next   = bit_reg + 7'd1;
                        if (bit_reg == 7'(`HCE_WORD_BITS - 1)) begin
                            state_next = ST_GUARD;
                        end
                    end
                end
            end
            ST_GUARD: begin
                led_n_next = 1'b0;
                cnt_next   = slot_end ? 32'd0 : cnt_reg + 32'd1;
                if (slot_end) begin
                    slot_next = slot_reg + 3'd1;
                    if (slot_reg == 3'(GUARD_SLOTS % 8)) begin
                        slot_next = 3'd0;
                    end
                end
                if (slot_end && slot_reg == 3'(GUARD_SLOTS % 8)) begin
                    words_next = words_reg + 8'h01;
                    blank_next = cfg[`HCE_CFG_BLANK_ALT] && !blank_reg;
                    bit_next   = 7'd0;
                    if (sw == 4'h0 || words_reg == 8'(MAX_WORDS - 1)) begin
                        state_next = ST_SLEEP;
                    end else begin
                        state_next = ST_SEND;
                    end
                end
            end
            ST_PROG: begin
                oe_next = 1'b0;
                if (!prog_en) begin
                    state_next  = ST_SLEEP;
                    verify_next = 1'b0;
                end else if (sclk_rise && !verify_reg) begin
                    shift_next = {pdata, shift_reg[15:1]};
                    pbit_next  = pbit_reg + 4'h1;
                    if (pbit_reg == 4'hf) begin
                        mem_we     = 1'b1;
                        mem_waddr  = pword_reg;
                        mem_wdata  = {pdata, shift_reg[15:1]};
                        pword_next = pword_reg + 4'h1;
                        if (pword_reg == `HCE_LAST_WORD) begin
                            pword_next  = 4'h0;
                            verify_next = 1'b1;
                        end
                    end
                end else if (verify_reg) begin
                    oe_next  = 1'b1;
                    pwm_next = mem[pword_reg][pbit_reg];
                    if (sclk_rise) begin
                        pbit_next = pbit_reg + 4'h1;
                        if (pbit_reg == 4'hf) begin
                            pword_next = (pword_reg == `HCE_LAST_WORD) ? 4'h0 :
                                         pword_reg + 4'h1;
                        end
                    end
                end
            end
            default: begin
                state_next = ST_SLEEP;
            end
        endcase
        // A new button during encryption or sending restarts the wake-up
        if ((state_reg == ST_ENCRYPT || state_reg == ST_SEND || state_reg == ST_GUARD) &&
            ((sw & ~btn_reg) != 4'h0)) begin
            state_next = ST_DEBOUNCE;
            cnt_next   = 32'd0;
            pwm_next   = 1'b0;
            led_n_next = 1'b1;
        end
        // Register port: writes to storage when idle, guarded reads
        if (i_write && state_reg == ST_SLEEP && i_addr <= `HCE_LAST_WORD) begin
            mem_we = 1'b1;
        end
        if (i_read) begin
            if (i_addr == `HCE_ADDR_CONFIG || i_addr == `HCE_ADDR_SER1 ||
                i_addr == `HCE_ADDR_SER0) begin
                rdata_next = mem[i_addr];
            end else if (i_addr <= `HCE_LAST_WORD && verify_reg) begin
                rdata_next = mem[i_addr];
            end else if (i_addr == `HCE_ADDR_STATUS) begin
                rdata_next = {7'h00, verify_reg, btn_reg, 1'b0, state_reg};
            end
        end
    end

    // Storage words
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mem[`HCE_ADDR_CONFIG] <= `HCE_CONFIG_RESET;
        end else if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // Register the control state
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_reg  <= ST_SLEEP;
            cnt_reg    <= 32'd0;
            btn_reg    <= 4'h0;
            word_reg   <= '0;
            bit_reg    <= 7'd0;
            slot_reg   <= 3'd0;
            words_reg  <= 8'h00;
            blank_reg  <= 1'b0;
            phase_reg  <= 1'b0;
            start_reg  <= 1'b0;
            shift_reg  <= 16'h0000;
            pbit_reg   <= 4'h0;
            pword_reg  <= 4'h0;
            verify_reg <= 1'b0;
            pwm_reg    <= 1'b0;
            oe_reg     <= 1'b1;
            led_n_reg  <= 1'b1;
            rdata_reg  <= 16'h0000;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            btn_reg    <= btn_next;
            word_reg   <= word_next;
            bit_reg    <= bit_next;
            slot_reg   <= slot_next;
            words_reg  <= words_next;
            blank_reg  <= blank_next;
            phase_reg  <= phase_next;
            start_reg  <= start_next;
            shift_reg  <= shift_next;
            pbit_reg   <= pbit_next;
            pword_reg  <= pword_next;
            verify_reg <= verify_next;
            pwm_reg    <= pwm_next;
            oe_reg     <= oe_next;
            led_n_reg  <= led_n_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign o_rdata  = rdata_reg;
    assign o_pwm    = pwm_reg;
    assign o_pwm_oe = oe_reg;
    assign o_led_n  = led_n_reg;
endmodule

// *** hce_consts.svh ***
// Purpose: Offsets, field positions and timing figures of the code word encoder
// Assumes: Included by its bare name; clock of 100 MHz
// Notes:   Definitions only
`ifndef HCE_CONSTS_SVH
`define HCE_CONSTS_SVH

// ----------------------------------------
// Storage word indices (plain port address)
// ----------------------------------------
`define HCE_NUM_WORDS      12
`define HCE_ADDR_KEY3      4'h3
`define HCE_ADDR_SYNC      4'h4
`define HCE_ADDR_SEED2     4'h5
`define HCE_ADDR_SEED0     4'h7
`define HCE_ADDR_SEED1     4'h8
`define HCE_ADDR_SER0      4'h9
`define HCE_ADDR_SER1      4'ha
`define HCE_ADDR_CONFIG    4'hb
`define HCE_ADDR_STATUS    4'hc
`define HCE_LAST_WORD      4'hb

// ----------------------------------------
// Configuration word fields and reset value
// ----------------------------------------
`define HCE_CFG_BLANK_ALT  0
`define HCE_CFG_FAST       1
`define HCE_CFG_FORMAT     2
`define HCE_CFG_SEED_EN    4
`define HCE_CFG_XSER       12
`define HCE_CFG_VPWM       14
`define HCE_CFG_OVR        15
`define HCE_CONFIG_RESET   16'h0000

// ----------------------------------------
// Button codes and word layout
// ----------------------------------------
`define HCE_SEED_CODE_A    4'h9
`define HCE_SEED_CODE_B    4'h3
`define HCE_WORD_BITS      67
`define HCE_SLOTS_WIDE     3
`define HCE_SLOTS_NARROW   6

// ----------------------------------------
// Timing
// ----------------------------------------
`define HCE_CLK_NS         10
`define HCE_CLK_HZ         100000000
`define HCE_DEBOUNCE_NS    6500000
`define HCE_RATE_SLOW_BPS  833
`define HCE_RATE_FAST_BPS  1667

`endif

// *** hce_pkg.sv ***
// Purpose: Types shared by the code word encoder
// Assumes: Nothing
// Notes:   Code word is sent from bit 0 upward
package hce_pkg;

    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_DEBOUNCE,
        ST_CAPTURE,
        ST_WRITEBACK,
        ST_ENCRYPT,
        ST_SEND,
        ST_GUARD,
        ST_PROG
    } hce_state_t;

    // 67-bit transmitted word, hop first on the line
    typedef struct packed {
        logic [1:0]  crc;
        logic        vlow;
        logic [31:0] fixed;
        logic [31:0] hop;
    } hce_code_word_t;

endpackage

// *** hce_cipher.sv ***
// Purpose: Replaceable 32-bit block transform under a 64-bit key
// Assumes: i_start is a one-cycle pulse while idle
// Notes:   One round per clock; o_done pulses once, o_block then stands
`timescale 1ns/1ns
module hce_cipher
    import hce_pkg::*;
#(
    parameter int          ROUNDS    = 64,
    parameter logic [31:0] NLF_TABLE = 32'h5a3c96e1  // Arbitrary mixing table
) (
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic        i_start,
    input  wire logic [31:0] i_block,
    input  wire logic [63:0] i_key,
    output logic      [31:0] o_block,
    output logic             o_done
);
    logic [31:0] block_reg, block_next;
    logic [63:0] key_reg,   key_next;
    logic [15:0] round_reg, round_next;
    logic        busy_reg,  busy_next;
    logic        done_reg,  done_next;
    logic        mix;

    // ----------------------------------------
    // Round function and sequencing
    // ----------------------------------------
    always_comb begin
        block_next = block_reg;
        key_next   = key_reg;
        round_next = round_reg;
        busy_next  = busy_reg;
        done_next  = 1'b0;
        mix = NLF_TABLE[{block_reg[31], block_reg[26], block_reg[20], block_reg[9],
                         block_reg[1]}] ^ block_reg[0] ^ block_reg[16] ^ key_reg[0];
        if (i_start && !busy_reg) begin
            block_next = i_block;
            key_next   = i_key;
            round_next = 16'h0000;
            busy_next  = 1'b1;
        end else if (busy_reg) begin
            block_next = {mix, block_reg[31:1]};
            key_next   = {key_reg[0], key_reg[63:1]};
            round_next = round_reg + 16'h0001;
            if (round_reg == 16'(ROUNDS - 1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    // Register the round state
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            block_reg <= 32'h0000_0000;
            key_reg   <= 64'h0;
            round_reg <= 16'h0000;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            block_reg <= block_next;
            key_reg   <= key_next;
            round_reg <= round_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
        end
    end

    assign o_block = block_reg;
    assign o_done  = done_reg;
endmodule

// *** hce_monitor.sv ***
// Purpose: Port assertions for the code word encoder
// Assumes: Pins pass two sync flops; programming mode unused by bench
// Notes:   Bound to hce_encoder below
`timescale 1ns/1ns
module hce_monitor (
    input wire logic        i_clock,
    input wire logic        i_reset,
    input wire logic [3:0]  i_switch_in,
    input wire logic        i_prog_enable,
    input wire logic [3:0]  i_addr,
    input wire logic        i_read,
    input wire logic [15:0] o_rdata,
    input wire logic        o_pwm,
    input wire logic        o_pwm_oe,
    input wire logic        o_led_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // A switch that was open one sample before reaches the logic closed while sending
    sequence s_new_button;
        !o_led_n && (($past(i_switch_in, 2) & ~$past(i_switch_in, 3)) != 4'h0);
    endsequence
    property p_abort; s_new_button |-> ##[1:4] (o_led_n && !o_pwm); endproperty
    property p_debounce; $rose(i_switch_in != 4'h0) && o_led_n |-> o_led_n [*8]; endproperty
    property p_reset; $past(i_reset) |-> o_led_n && o_pwm_oe && o_rdata == 16'h0000; endproperty
    property p_rdata_idle; !$past(i_read) |-> o_rdata == 16'h0000; endproperty
    property p_unmapped; $past(i_read) && $past(i_addr) > 4'hc |-> o_rdata == 16'h0000; endproperty
    property p_guarded;
        $past(i_read) && $past(i_addr) <= 4'h8 && !$past(i_prog_enable) && !$past(i_prog_enable, 4)
            |-> o_rdata == 16'h0000;
    endproperty
    property p_pwm_led; o_pwm && !$past(i_prog_enable, 3) |-> !o_led_n && o_pwm_oe; endproperty
    property p_prog_oe;
        !o_pwm_oe |-> $past(i_prog_enable, 2) || $past(i_prog_enable, 3) || $past(i_prog_enable, 4);
    endproperty
    a_abort: assert property (p_abort) else $error("word not abandoned");
    a_debounce: assert property (p_debounce) else $error("sent before debounce");
    a_reset: assert property (p_reset) else $error("bad state after reset");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_guarded: assert property (p_guarded) else $error("protected word readable");
    a_pwm_led: assert property (p_pwm_led) else $error("pulse without indicator");
    a_prog_oe: assert property (p_prog_oe) else $error("pin released outside prog");
endmodule
bind hce_encoder hce_monitor hce_monitor_inst (.*);

// *** hce_rf_model.sv ***
// Purpose: RF side model counting pulses of the modulated output
// Assumes: Every transmitted bit starts with one rise of the line
// Notes:   A released line shows the inverse of its last level
`timescale 1ns/1ns
module hce_rf_model (
    input  wire logic        i_clock,
    input  wire logic        i_clear,
    input  wire logic        i_pwm,
    input  wire logic        i_pwm_oe,
    output logic             o_line,
    output logic      [15:0] o_pulses,
    output logic      [15:0] o_period
);
    logic        last_reg = 1'b0;
    logic [15:0] gap_reg = 16'h0000;
    // Shared pin level
    assign o_line = i_pwm_oe ? i_pwm : ~last_reg;
    // Count rises and cycles between them
    always_ff @(posedge i_clock) begin
        last_reg <= o_line;
        gap_reg  <= gap_reg + 16'h0001;
        if (i_clear) begin
            o_pulses <= 16'h0000;
        end else if (o_line && !last_reg && i_pwm_oe) begin
            o_pulses <= o_pulses + 16'h0001;
            o_period <= gap_reg + 16'h0001;
            gap_reg  <= 16'h0000;
        end
    end
endmodule

// *** test_hce_encoder.sv ***
// Purpose: Self-checking bench for the code word encoder
// Assumes: Debounce 20, bit 36 or 18 cycles, 3 words before time-out
// Notes:   Programming mode and low battery are held off
`timescale 1ns/1ns
module test_hce_encoder;
    logic        i_clock, i_reset, i_write, i_read, clr, line, o_pwm, o_pwm_oe, o_led_n;
    logic        lowbat_pin, alt_pin;
    logic [3:0]  i_switch_in, i_addr;
    logic [15:0] i_wdata, o_rdata, pulses, period;
    int          err_count = 0;
    int          samples_checked = 0;
    hce_encoder #(.DEBOUNCE_CYC(20), .BIT_CYC_SLOW(36), .BIT_CYC_FAST(18), .MAX_WORDS(3))
        hce_encoder_inst (.i_clock(i_clock), .i_reset(i_reset), .i_switch_in(i_switch_in),
        .i_low_battery(lowbat_pin), .i_prog_enable(1'b0), .i_prog_clock_alt(alt_pin),
        .i_pwm_data(line), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata), .o_pwm(o_pwm), .o_pwm_oe(o_pwm_oe),
        .o_led_n(o_led_n));
    hce_rf_model hce_rf_model_inst (.i_clock(i_clock), .i_clear(clr), .i_pwm(o_pwm),
        .i_pwm_oe(o_pwm_oe), .o_line(line), .o_pulses(pulses), .o_period(period));
    // Clock and watchdog
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial begin
        repeat (60000) @(posedge i_clock);
        err_count++;
        report_and_stop;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask
    task automatic wait_led(input logic lvl, input int lim);
        int n;
        n = 0;
        #1;
        while (o_led_n !== lvl && n < lim) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        chk({15'h0000, o_led_n}, {15'h0000, lvl});
    endtask
    // Press a button, hold or release, then check pulse count and bit period
    task automatic run(input logic [15:0] cfg, input int hold, input logic [15:0] np,
                       input logic [15:0] per);
        wr(4'hb, cfg);
        clr <= 1'b1;
        @(posedge i_clock);
        clr <= 1'b0;
        i_switch_in <= 4'h1;
        wait_led(1'b0, 300);
        repeat (hold) @(posedge i_clock);
        @(posedge i_clock);
        if (hold > 0) i_switch_in <= 4'h0;
        wait_led(1'b1, 12000);
        @(posedge i_clock);
        i_switch_in <= 4'h0;
        repeat (60) @(posedge i_clock);
        chk(pulses, np);
        chk(period, per);
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {i_reset, i_write, i_read, clr, i_switch_in, i_addr, i_wdata} = {4'hd, 24'h0};
        lowbat_pin = 1'b0;
        alt_pin    = 1'b0;
        repeat (8) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
        #1;
        chk({o_led_n, o_pwm_oe, o_rdata}, 18'h30000);
        for (int k = 0; k < 11; k++) wr(4'(k), {12'h5a0, 4'(k)});
        rd(4'h9, 16'h5a09);
        rd(4'h0, 16'h0000);
        rd(4'h4, 16'h0000);
        rd(4'hd, 16'h0000);
        run(16'h0000, 0, 16'h00c9, 16'h0024);
        run(16'h0002, 100, 16'h0043, 16'h0012);
        run(16'h0004, 100, 16'h0043, 16'h0024);
        run(16'h0001, 0, 16'h0086, 16'h0024);
        rd(4'hb, 16'h0001);
        @(posedge i_clock);
        i_switch_in <= 4'h1;
        wait_led(1'b0, 300);
        repeat (50) @(posedge i_clock);
        i_switch_in <= 4'h3;
        wait_led(1'b1, 5);
        @(posedge i_clock);
        i_switch_in <= 4'h0;
        repeat (100) @(posedge i_clock);
        report_and_stop;
    end
endmodule
